/* hw/expert_test_regs.svh */
`ifndef EXPERT_TEST_REGS_SVH
`define EXPERT_TEST_REGS_SVH

// Register offsets on the serial control interface
`define OFS_FINE_TUNE_CONTROLS 7'h34
`define OFS_DIAG_DIGITAL_SELECT 7'h35
`define OFS_DIAG_ANALOG_SELECT 7'h36
`define OFS_DIAG_REGULATOR_FORCE 7'h37
`define OFS_DIAG_BLOCK_FORCE 7'h38

// Reset values
`define RST_BANK 8'h00

// Writable bits of the fine tune register, upper nibble reads zero
`define FINE_TUNE_WMASK 8'h0f

// Fine tune register fields
`define FT_BUFFER_CAL_BIT 3
`define FT_REG_MODE_BIT 2
`define FT_PHASE_LIMIT_BIT 1
`define FT_PROTECT_CAL_BIT 0

// Digital select register fields
`define DD_MULTITONE_BIT 7
`define DD_PROBE_MSB 6
`define DD_PROBE_LSB 4
`define DD_RX_PROBE_MSB 3
`define DD_RX_PROBE_LSB 0

// Analog select register fields
`define DA_LOW_VOLT_BIT 7
`define DA_PROBE_MSB 6
`define DA_PROBE_LSB 4
`define DA_SUPPLY_OFF_BIT 3
`define DA_PLL_CFG_MSB 2
`define DA_PLL_CFG_LSB 1
`define DA_OSC_TEST_BIT 0

// Regulator force register fields
`define RF_OSC_ON_BIT 7
`define RF_PLL_ON_BIT 6
`define RF_AMP_ON_BIT 5
`define RF_OSC_RDY_BIT 4
`define RF_PLL_RDY_BIT 3
`define RF_AMP_RDY_BIT 2
`define RF_LOCK_BIT 1
`define RF_XTAL_RDY_BIT 0

// Block force register: bits 7..1 enable blocks, bit 0 step bypass
`define BF_ENABLE_MSB 7
`define BF_ENABLE_LSB 1
`define BF_STEP_BYPASS_BIT 0

// Demodulator delay line lengths per select code
`define DELAY_LEN_00 6'd40
`define DELAY_LEN_01 6'd13
`define DELAY_LEN_10 6'd20
`define DELAY_LEN_11 6'd7

// RSSI filter added capacitance in pF per trim code
`define CAP_PF_00 4'd0
`define CAP_PF_01 4'd2
`define CAP_PF_10 4'd5
`define CAP_PF_11 4'd12

`endif

/* hw/expert_test_pkg.sv */
package expert_test_pkg;

  typedef logic [6:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [5:0] delay_len_t;
  typedef logic [3:0] cap_pf_t;
  typedef logic [2:0] probe_sel_t;
  typedef logic [3:0] rx_probe_t;
  typedef logic [1:0] sel2_t;
  typedef logic [6:0] block_en_t;

endpackage

/* hw/expert_test_control_bank.sv */
// Overview of operation
// - Demod select upper bit picks 300/600 kHz centre; lower bit picks input range.
// - Delay line length is 40, 13, 20 or 7 elements for codes 00..11.
// - RSSI trim adds none, 2, 5 or 12 pF for codes 00..11.
// - Test-buffer calibration bit high switches the calibration path on.
// - Mode bit zero: regulator force bits are ORed onto normal control lines.
// - Mode bit one: force bits 7..5 replace normal supply lines; status force bits 4..0 are still ORed.
// - Phase-trim limit bit zero searches all; one excludes certain phase trims.
// - Protect bit one delays requested PLL startup until timer calibration ends.
// - Every test register bit clears to zero at power-up.
// - Digital select bit 7 enables channel filter multi-tone testing.
// - Digital select bits 6..4 pick probe signals; low bits pick receive probes.
// - Analog select holds probe select, digital supply off, PLL test, oscillator test.
// - Regulator force bits 7, 6, 5 enable oscillator, PLL and amplifier supplies.
// - Regulator force bits 4..0 force supply ready, lock and crystal ready asserted.
// - Forced status lets startup sequences proceed despite a failing block.
// - Block force bits 7..1 enable oscillator, divider, detector, clock, TX, bandgap, RX.
// - Block force bit 0 enables amplifier step-decoding bypass test mode.
`timescale 1ns/1ps
`include "expert_test_regs.svh"

module expert_test_control_bank (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Register port from the serial interface decoder
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire expert_test_pkg::reg_addr_t REG_ADDR_I,
  input wire expert_test_pkg::reg_byte_t REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  output logic REG_HIT_O,
  // Demodulator and RSSI fields of the preceding expert register
  input wire expert_test_pkg::sel2_t DEMOD_SEL_I,
  input wire expert_test_pkg::sel2_t RSSI_FILTER_CAP_TRIM_I,
  output logic DEMOD_CENTRE_600K_O,
  output logic DEMOD_WIDE_RANGE_O,
  output logic [5:0] DEMOD_DELAY_LEN_O,
  output logic [3:0] RSSI_CAP_PF_O,
  // Fine tune controls
  output logic BUFFER_CAL_PATH_ON_O,
  output logic PHASE_TRIM_LIMIT_O,
  input wire logic PLL_START_REQ_I,
  input wire logic TIMER_CAL_BUSY_I,
  output logic PLL_START_O,
  // Digital and analog probe selection
  output logic FILTER_MULTITONE_TEST_O,
  output logic [2:0] DIGITAL_PROBE_SELECT_O,
  output logic [3:0] RECEIVE_PROBE_SELECT_O,
  output logic IF_BUFFER_LOW_VOLTAGE_O,
  output logic [2:0] ANALOG_PROBE_SELECT_O,
  output logic DIGITAL_SUPPLY_OFF_O,
  output logic [1:0] PLL_TEST_CONFIG_O,
  output logic OSCILLATOR_TEST_ENABLE_O,
  // Regulator control
  input wire logic NORMAL_OSC_SUPPLY_I,
  input wire logic NORMAL_PLL_SUPPLY_I,
  input wire logic NORMAL_AMP_SUPPLY_I,
  output logic OSC_SUPPLY_EN_O,
  output logic PLL_SUPPLY_EN_O,
  output logic AMP_SUPPLY_EN_O,
  // Status seen by the startup sequencers
  input wire logic OSC_SUPPLY_READY_I,
  input wire logic PLL_SUPPLY_READY_I,
  input wire logic AMP_SUPPLY_READY_I,
  input wire logic PLL_LOCK_I,
  input wire logic CRYSTAL_READY_I,
  output logic OSC_SUPPLY_READY_O,
  output logic PLL_SUPPLY_READY_O,
  output logic AMP_SUPPLY_READY_O,
  output logic PLL_LOCK_O,
  output logic CRYSTAL_READY_O,
  // Block enables, bit 6 oscillator down to bit 0 receiver
  input wire expert_test_pkg::block_en_t NORMAL_BLOCK_EN_I,
  output logic OSC_BLOCK_ENABLE_O,
  output logic DIVIDER_ENABLE_O,
  output logic PHASE_DETECTOR_ENABLE_O,
  output logic PLL_CLOCK_ENABLE_O,
  output logic TX_SECTION_ENABLE_O,
  output logic RECEIVE_BANDGAP_ENABLE_O,
  output logic RECEIVER_ENABLE_O,
  output logic AMP_STEP_BYPASS_O
);
  import expert_test_pkg::*;

  // Regulator drive: OR mode or full replacement mode
  function automatic logic supply_drive(input logic normal, input logic force_on, input logic replace);
    supply_drive = replace ? force_on : (normal | force_on);
  endfunction

  // Delay line length for a demodulator select code
  function automatic delay_len_t delay_len(input sel2_t sel);
    unique case (sel)
      2'b00: delay_len = `DELAY_LEN_00;
      2'b01: delay_len = `DELAY_LEN_01;
      2'b10: delay_len = `DELAY_LEN_10;
      2'b11: delay_len = `DELAY_LEN_11;
    endcase
  endfunction

  // Added RSSI capacitance for a trim code
  function automatic cap_pf_t cap_pf(input sel2_t sel);
    unique case (sel)
      2'b00: cap_pf = `CAP_PF_00;
      2'b01: cap_pf = `CAP_PF_01;
      2'b10: cap_pf = `CAP_PF_10;
      2'b11: cap_pf = `CAP_PF_11;
    endcase
  endfunction

  // One-hot register select for an address; all zero when unmapped
  function automatic logic [4:0] reg_select(input reg_addr_t addr);
    unique case (addr)
      `OFS_FINE_TUNE_CONTROLS: reg_select = 5'h01;
      `OFS_DIAG_DIGITAL_SELECT: reg_select = 5'h02;
      `OFS_DIAG_ANALOG_SELECT: reg_select = 5'h04;
      `OFS_DIAG_REGULATOR_FORCE: reg_select = 5'h08;
      `OFS_DIAG_BLOCK_FORCE: reg_select = 5'h10;
      default: reg_select = 5'h00;
    endcase
  endfunction

  reg_byte_t fine_tune_controls_r, fine_tune_controls_nxt;
  reg_byte_t diag_digital_select_r, diag_digital_select_nxt;
  reg_byte_t diag_analog_select_r, diag_analog_select_nxt;
  reg_byte_t diag_regulator_force_r, diag_regulator_force_nxt;
  reg_byte_t diag_block_force_r, diag_block_force_nxt;
  reg_byte_t rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic hit_r, hit_nxt;
  logic addr_hit;
  logic [4:0] reg_sel;

  // Address decode shared by reads and writes
  always_comb begin
    reg_sel = reg_select(REG_ADDR_I);
    addr_hit = |reg_sel;
  end

  // Register writes and read data
  always_comb begin
    fine_tune_controls_nxt = fine_tune_controls_r;
    diag_digital_select_nxt = diag_digital_select_r;
    diag_analog_select_nxt = diag_analog_select_r;
    diag_regulator_force_nxt = diag_regulator_force_r;
    diag_block_force_nxt = diag_block_force_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = REG_RD_I;
    hit_nxt = (REG_RD_I | REG_WR_I) & addr_hit;
    // Writes to unmapped addresses select nothing and are dropped
    if (REG_WR_I && reg_sel[0]) begin
      fine_tune_controls_nxt = REG_WDATA_I & `FINE_TUNE_WMASK;
    end
    if (REG_WR_I && reg_sel[1]) begin
      diag_digital_select_nxt = REG_WDATA_I;
    end
    if (REG_WR_I && reg_sel[2]) begin
      diag_analog_select_nxt = REG_WDATA_I;
    end
    if (REG_WR_I && reg_sel[3]) begin
      diag_regulator_force_nxt = REG_WDATA_I;
    end
    if (REG_WR_I && reg_sel[4]) begin
      diag_block_force_nxt = REG_WDATA_I;
    end
    // A read returns the old value even when a write hits the same cycle; unmapped reads zero
    if (REG_RD_I) begin
      rdata_nxt = ({8{reg_sel[0]}} & fine_tune_controls_r) | ({8{reg_sel[1]}} & diag_digital_select_r)
                | ({8{reg_sel[2]}} & diag_analog_select_r) | ({8{reg_sel[3]}} & diag_regulator_force_r)
                | ({8{reg_sel[4]}} & diag_block_force_r);
    end
  end

  // Register state, cleared at reset
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      fine_tune_controls_r <= `RST_BANK;
      diag_digital_select_r <= `RST_BANK;
      diag_analog_select_r <= `RST_BANK;
      diag_regulator_force_r <= `RST_BANK;
      diag_block_force_r <= `RST_BANK;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      hit_r <= 1'b0;
    end else begin
      fine_tune_controls_r <= fine_tune_controls_nxt;
      diag_digital_select_r <= diag_digital_select_nxt;
      diag_analog_select_r <= diag_analog_select_nxt;
      diag_regulator_force_r <= diag_regulator_force_nxt;
      diag_block_force_r <= diag_block_force_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign REG_RDATA_O = rdata_r;
  assign REG_RVALID_O = rvalid_r;
  assign REG_HIT_O = hit_r;

  // Derived control outputs, next values
  logic centre_nxt, wide_nxt, buf_cal_nxt, phase_lim_nxt, pll_start_nxt;
  delay_len_t delay_nxt;
  cap_pf_t cap_nxt;
  logic osc_sup_nxt, pll_sup_nxt, amp_sup_nxt;
  logic [4:0] ready_nxt;
  block_en_t block_nxt;
  logic replace_mode;
  logic multitone_nxt;
  probe_sel_t dprobe_nxt;
  rx_probe_t rx_probe_nxt;
  logic low_volt_nxt;
  probe_sel_t aprobe_nxt;
  logic supply_off_nxt;
  sel2_t pll_cfg_nxt;
  logic osc_test_nxt;
  logic step_bypass_nxt;

  always_comb begin
    replace_mode = fine_tune_controls_r[`FT_REG_MODE_BIT];
    // Demodulator and RSSI decode of the preceding register's fields
    centre_nxt = DEMOD_SEL_I[1];
    wide_nxt = DEMOD_SEL_I[0];
    delay_nxt = delay_len(DEMOD_SEL_I);
    cap_nxt = cap_pf(RSSI_FILTER_CAP_TRIM_I);
    buf_cal_nxt = fine_tune_controls_r[`FT_BUFFER_CAL_BIT];
    phase_lim_nxt = fine_tune_controls_r[`FT_PHASE_LIMIT_BIT];
    // Hold PLL start off while protected timer calibration runs
    pll_start_nxt = PLL_START_REQ_I & ~(fine_tune_controls_r[`FT_PROTECT_CAL_BIT] & TIMER_CAL_BUSY_I);
    // Supply enables: force bits add to or replace the normal lines
    osc_sup_nxt = supply_drive(NORMAL_OSC_SUPPLY_I, diag_regulator_force_r[`RF_OSC_ON_BIT], replace_mode);
    pll_sup_nxt = supply_drive(NORMAL_PLL_SUPPLY_I, diag_regulator_force_r[`RF_PLL_ON_BIT], replace_mode);
    amp_sup_nxt = supply_drive(NORMAL_AMP_SUPPLY_I, diag_regulator_force_r[`RF_AMP_ON_BIT], replace_mode);
    // Forced status bits make sequencers see ready
    ready_nxt = {OSC_SUPPLY_READY_I, PLL_SUPPLY_READY_I, AMP_SUPPLY_READY_I, PLL_LOCK_I, CRYSTAL_READY_I}
                | diag_regulator_force_r[`RF_OSC_RDY_BIT:`RF_XTAL_RDY_BIT];
    // Block enables: force bits can only add to the normal lines
    block_nxt = NORMAL_BLOCK_EN_I | diag_block_force_r[`BF_ENABLE_MSB:`BF_ENABLE_LSB];
  end

  // Probe and test selections taken straight from the diagnostic registers
  always_comb begin
    multitone_nxt = diag_digital_select_r[`DD_MULTITONE_BIT];
    dprobe_nxt = diag_digital_select_r[`DD_PROBE_MSB:`DD_PROBE_LSB];
    rx_probe_nxt = diag_digital_select_r[`DD_RX_PROBE_MSB:`DD_RX_PROBE_LSB];
    // Low-voltage buffer bit is only passed on; the host decides when it is needed
    low_volt_nxt = diag_analog_select_r[`DA_LOW_VOLT_BIT];
    aprobe_nxt = diag_analog_select_r[`DA_PROBE_MSB:`DA_PROBE_LSB];
    supply_off_nxt = diag_analog_select_r[`DA_SUPPLY_OFF_BIT];
    pll_cfg_nxt = diag_analog_select_r[`DA_PLL_CFG_MSB:`DA_PLL_CFG_LSB];
    osc_test_nxt = diag_analog_select_r[`DA_OSC_TEST_BIT];
    step_bypass_nxt = diag_block_force_r[`BF_STEP_BYPASS_BIT];
  end

  // Output flip-flops
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      DEMOD_CENTRE_600K_O <= 1'b0;
      DEMOD_WIDE_RANGE_O <= 1'b0;
      DEMOD_DELAY_LEN_O <= `DELAY_LEN_00;
      RSSI_CAP_PF_O <= `CAP_PF_00;
      BUFFER_CAL_PATH_ON_O <= 1'b0;
      PHASE_TRIM_LIMIT_O <= 1'b0;
      PLL_START_O <= 1'b0;
      FILTER_MULTITONE_TEST_O <= 1'b0;
      DIGITAL_PROBE_SELECT_O <= 3'h0;
      RECEIVE_PROBE_SELECT_O <= 4'h0;
      IF_BUFFER_LOW_VOLTAGE_O <= 1'b0;
      ANALOG_PROBE_SELECT_O <= 3'h0;
      DIGITAL_SUPPLY_OFF_O <= 1'b0;
      PLL_TEST_CONFIG_O <= 2'h0;
      OSCILLATOR_TEST_ENABLE_O <= 1'b0;
      OSC_SUPPLY_EN_O <= 1'b0;
      PLL_SUPPLY_EN_O <= 1'b0;
      AMP_SUPPLY_EN_O <= 1'b0;
      {OSC_SUPPLY_READY_O, PLL_SUPPLY_READY_O, AMP_SUPPLY_READY_O, PLL_LOCK_O, CRYSTAL_READY_O} <= 5'h00;
      {OSC_BLOCK_ENABLE_O, DIVIDER_ENABLE_O, PHASE_DETECTOR_ENABLE_O, PLL_CLOCK_ENABLE_O,
       TX_SECTION_ENABLE_O, RECEIVE_BANDGAP_ENABLE_O, RECEIVER_ENABLE_O} <= 7'h00;
      AMP_STEP_BYPASS_O <= 1'b0;
    end else begin
      DEMOD_CENTRE_600K_O <= centre_nxt;
      DEMOD_WIDE_RANGE_O <= wide_nxt;
      DEMOD_DELAY_LEN_O <= delay_nxt;
      RSSI_CAP_PF_O <= cap_nxt;
      BUFFER_CAL_PATH_ON_O <= buf_cal_nxt;
      PHASE_TRIM_LIMIT_O <= phase_lim_nxt;
      PLL_START_O <= pll_start_nxt;
      FILTER_MULTITONE_TEST_O <= multitone_nxt;
      DIGITAL_PROBE_SELECT_O <= dprobe_nxt;
      RECEIVE_PROBE_SELECT_O <= rx_probe_nxt;
      IF_BUFFER_LOW_VOLTAGE_O <= low_volt_nxt;
      ANALOG_PROBE_SELECT_O <= aprobe_nxt;
      DIGITAL_SUPPLY_OFF_O <= supply_off_nxt;
      PLL_TEST_CONFIG_O <= pll_cfg_nxt;
      OSCILLATOR_TEST_ENABLE_O <= osc_test_nxt;
      OSC_SUPPLY_EN_O <= osc_sup_nxt;
      PLL_SUPPLY_EN_O <= pll_sup_nxt;
      AMP_SUPPLY_EN_O <= amp_sup_nxt;
      {OSC_SUPPLY_READY_O, PLL_SUPPLY_READY_O, AMP_SUPPLY_READY_O, PLL_LOCK_O, CRYSTAL_READY_O} <= ready_nxt;
      {OSC_BLOCK_ENABLE_O, DIVIDER_ENABLE_O, PHASE_DETECTOR_ENABLE_O, PLL_CLOCK_ENABLE_O,
       TX_SECTION_ENABLE_O, RECEIVE_BANDGAP_ENABLE_O, RECEIVER_ENABLE_O} <= block_nxt;
      AMP_STEP_BYPASS_O <= step_bypass_nxt;
    end
  end

endmodule

/* sim/bank_check_sva.sv */
`timescale 1ns/1ps
module bank_check (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic REG_RD_I,
  input wire logic REG_RVALID_O,
  input wire logic REG_HIT_O,
  input wire expert_test_pkg::sel2_t DEMOD_SEL_I,
  input wire expert_test_pkg::sel2_t RSSI_FILTER_CAP_TRIM_I,
  input wire logic DEMOD_CENTRE_600K_O,
  input wire logic DEMOD_WIDE_RANGE_O,
  input wire logic [5:0] DEMOD_DELAY_LEN_O,
  input wire logic [3:0] RSSI_CAP_PF_O,
  input wire logic PLL_START_REQ_I,
  input wire logic TIMER_CAL_BUSY_I,
  input wire logic PLL_START_O,
  input wire logic PLL_LOCK_I,
  input wire logic PLL_LOCK_O,
  input wire expert_test_pkg::block_en_t NORMAL_BLOCK_EN_I,
  input wire logic RECEIVER_ENABLE_O,
  input wire logic AMP_STEP_BYPASS_O
);
  import expert_test_pkg::*;
  localparam logic [5:0] DLY [4] = '{6'd40, 6'd13, 6'd20, 6'd7};
  localparam logic [3:0] CAP [4] = '{4'd0, 4'd2, 4'd5, 4'd12};
  logic [1:0] up_r;
  logic [1:0] up_nxt;
  logic ok;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // Counts edges since reset release so pipeline checks skip the flush
  always_comb begin
    up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
    if (RST_I) begin
      up_nxt = 2'h0;
    end
  end
  always_ff @(posedge REF_CLK_I) begin
    up_r <= up_nxt;
  end
  assign ok = (up_r == 2'h3);
  // Decoded fields follow the select codes one cycle later
  centre_sel_a: assert property (ok |-> {DEMOD_CENTRE_600K_O, DEMOD_WIDE_RANGE_O} == $past(DEMOD_SEL_I))
    else $error("demodulator centre or range wrong");
  delay_len_a: assert property (ok |=> DEMOD_DELAY_LEN_O == DLY[$past(DEMOD_SEL_I)])
    else $error("delay line length wrong");
  cap_trim_a: assert property (ok |=> RSSI_CAP_PF_O == CAP[$past(RSSI_FILTER_CAP_TRIM_I)])
    else $error("filter capacitance wrong");
  start_free_a: assert property (ok && PLL_START_REQ_I && !TIMER_CAL_BUSY_I |=> PLL_START_O)
    else $error("idle timer held back startup");
  start_cause_a: assert property (ok && PLL_START_O |-> $past(PLL_START_REQ_I))
    else $error("startup without request");
  ready_pass_a: assert property (ok && PLL_LOCK_I |=> PLL_LOCK_O)
    else $error("lock status lost");
  block_pass_a: assert property (ok && NORMAL_BLOCK_EN_I[0] |=> RECEIVER_ENABLE_O)
    else $error("receiver enable lost");
  read_valid_a: assert property (ok |-> REG_RVALID_O == $past(REG_RD_I))
    else $error("read valid timing wrong");
  reset_clear_a: assert property (disable iff (1'b0) RST_I |=> !REG_HIT_O && !PLL_LOCK_O && !AMP_STEP_BYPASS_O)
    else $error("outputs not cleared by reset");
  cover property (ok && PLL_START_REQ_I && TIMER_CAL_BUSY_I ##1 !PLL_START_O);
  cover property (REG_RVALID_O && REG_HIT_O);
  cover property (AMP_STEP_BYPASS_O);
endmodule
bind expert_test_control_bank bank_check chk_u (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .REG_RD_I(REG_RD_I),
  .REG_RVALID_O(REG_RVALID_O), .REG_HIT_O(REG_HIT_O), .DEMOD_SEL_I(DEMOD_SEL_I),
  .RSSI_FILTER_CAP_TRIM_I(RSSI_FILTER_CAP_TRIM_I), .DEMOD_CENTRE_600K_O(DEMOD_CENTRE_600K_O),
  .DEMOD_WIDE_RANGE_O(DEMOD_WIDE_RANGE_O), .DEMOD_DELAY_LEN_O(DEMOD_DELAY_LEN_O), .RSSI_CAP_PF_O(RSSI_CAP_PF_O),
  .PLL_START_REQ_I(PLL_START_REQ_I), .TIMER_CAL_BUSY_I(TIMER_CAL_BUSY_I), .PLL_START_O(PLL_START_O),
  .PLL_LOCK_I(PLL_LOCK_I), .PLL_LOCK_O(PLL_LOCK_O), .NORMAL_BLOCK_EN_I(NORMAL_BLOCK_EN_I),
  .RECEIVER_ENABLE_O(RECEIVER_ENABLE_O), .AMP_STEP_BYPASS_O(AMP_STEP_BYPASS_O));

/* sim/host_model.sv */
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  output logic wr_o,
  output logic rd_o,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  input wire logic hit_i
);
  // Idle bus with strobes low
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 7'h00;
    wdata_o = 8'h00;
  end
  // One access; diagnostic registers are only touched when a test asks for it
  task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic v, output logic h);
    @(posedge clk_i);
    #1;
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    q = rdata_i;
    v = rvalid_i;
    h = hit_i;
    wr_o = 1'b0;
    rd_o = 1'b0;
    // Released lines show the inverse so stale values never look valid
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import expert_test_pkg::*;
  localparam logic [5:0] DLY [4] = '{6'd40, 6'd13, 6'd20, 6'd7};
  localparam logic [3:0] CAP [4] = '{4'd0, 4'd2, 4'd5, 4'd12};
  int errors = 0;
  int tests_run = 0;
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, busy = 1'b0, wr, rd, rvalid, hit, start, v, h;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, q;
  // Buses gathered bit by bit from separate output pins are nets
  wire [7:0] dg, an, blk;
  sel2_t dsel = 2'h0, trim = 2'h0;
  wire [1:0] cw, ft;
  logic [5:0] dly;
  logic [3:0] cap;
  logic [2:0] nsup = 3'h0;
  wire [2:0] sup;
  logic [4:0] rdy_i = 5'h00;
  wire [4:0] rdy_o;
  block_en_t nblk = 7'h00;
  always #50 clk = ~clk;
  expert_test_control_bank dut_u (.REF_CLK_I(clk), .RST_I(rst), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .REG_HIT_O(hit), .DEMOD_SEL_I(dsel),
    .RSSI_FILTER_CAP_TRIM_I(trim), .DEMOD_CENTRE_600K_O(cw[1]), .DEMOD_WIDE_RANGE_O(cw[0]),
    .DEMOD_DELAY_LEN_O(dly), .RSSI_CAP_PF_O(cap), .BUFFER_CAL_PATH_ON_O(ft[1]), .PHASE_TRIM_LIMIT_O(ft[0]),
    .PLL_START_REQ_I(req), .TIMER_CAL_BUSY_I(busy), .PLL_START_O(start), .FILTER_MULTITONE_TEST_O(dg[7]),
    .DIGITAL_PROBE_SELECT_O(dg[6:4]), .RECEIVE_PROBE_SELECT_O(dg[3:0]), .IF_BUFFER_LOW_VOLTAGE_O(an[7]),
    .ANALOG_PROBE_SELECT_O(an[6:4]), .DIGITAL_SUPPLY_OFF_O(an[3]), .PLL_TEST_CONFIG_O(an[2:1]),
    .OSCILLATOR_TEST_ENABLE_O(an[0]), .NORMAL_OSC_SUPPLY_I(nsup[2]), .NORMAL_PLL_SUPPLY_I(nsup[1]),
    .NORMAL_AMP_SUPPLY_I(nsup[0]), .OSC_SUPPLY_EN_O(sup[2]), .PLL_SUPPLY_EN_O(sup[1]), .AMP_SUPPLY_EN_O(sup[0]),
    .OSC_SUPPLY_READY_I(rdy_i[4]), .PLL_SUPPLY_READY_I(rdy_i[3]), .AMP_SUPPLY_READY_I(rdy_i[2]),
    .PLL_LOCK_I(rdy_i[1]), .CRYSTAL_READY_I(rdy_i[0]), .OSC_SUPPLY_READY_O(rdy_o[4]),
    .PLL_SUPPLY_READY_O(rdy_o[3]), .AMP_SUPPLY_READY_O(rdy_o[2]), .PLL_LOCK_O(rdy_o[1]),
    .CRYSTAL_READY_O(rdy_o[0]), .NORMAL_BLOCK_EN_I(nblk), .OSC_BLOCK_ENABLE_O(blk[7]), .DIVIDER_ENABLE_O(blk[6]),
    .PHASE_DETECTOR_ENABLE_O(blk[5]), .PLL_CLOCK_ENABLE_O(blk[4]), .TX_SECTION_ENABLE_O(blk[3]),
    .RECEIVE_BANDGAP_ENABLE_O(blk[2]), .RECEIVER_ENABLE_O(blk[1]), .AMP_STEP_BYPASS_O(blk[0]));
  host_model host_u (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata),
    .rvalid_i(rvalid), .hit_i(hit));
  // Register access helpers and a one-cycle pipeline wait
  task automatic wreg(input logic [6:0] a, input logic [7:0] d);
    host_u.access(1'b1, a, d, q, v, h);
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e, input logic eh);
    host_u.access(1'b0, a, 8'h00, q, v, h);
    `CHK({q, v, h}, {e, 1'b1, eh})
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // Power-up state, readback, unmapped access
  task automatic t_regs();
    `CHK({dg, an, blk, sup, rdy_o, ft, start, dly}, {35'h0, 6'd40})
    for (int i = 0; i < 5; i++) begin
      rchk(7'h34 + i[6:0], 8'h00, 1'b1);
    end
    wreg(7'h34, 8'hff);
    rchk(7'h34, 8'h0f, 1'b1);
    for (int i = 1; i < 5; i++) begin
      wreg(7'h34 + i[6:0], 8'ha5);
      rchk(7'h34 + i[6:0], 8'ha5, 1'b1);
      wreg(7'h34 + i[6:0], 8'h00);
    end
    wreg(7'h39, 8'hff);
    rchk(7'h39, 8'h00, 1'b0);
  endtask
  // Every select and trim code
  task automatic t_demod();
    for (int c = 0; c < 4; c++) begin
      dsel = c[1:0];
      trim = c[1:0];
      step();
      `CHK({cw, dly, cap}, {c[1:0], DLY[c], CAP[c]})
    end
  endtask
  // Fine tune levels, regulator modes, gated startup
  task automatic t_fine();
    wreg(7'h34, 8'h0a);
    step();
    `CHK(ft, 2'h3)
    nsup = 3'b010;
    wreg(7'h34, 8'h00);
    wreg(7'h37, 8'h80);
    step();
    `CHK({ft, sup}, 5'b00110)
    wreg(7'h34, 8'h04);
    step();
    `CHK(sup, 3'b100)
    nsup = 3'h7;
    wreg(7'h37, 8'h20);
    step();
    `CHK(sup, 3'b001)
    wreg(7'h34, 8'h01);
    nsup = 3'h0;
    busy = 1'b1;
    req = 1'b1;
    step();
    `CHK({sup, start}, 4'b0010)
    busy = 1'b0;
    step();
    `CHK(start, 1'b1)
    busy = 1'b1;
    wreg(7'h34, 8'h00);
    step();
    `CHK(start, 1'b1)
    req = 1'b0;
  endtask
  // Status overrides, block enables, probe selectors
  task automatic t_force();
    wreg(7'h37, 8'h1f);
    step();
    `CHK(rdy_o, 5'h1f)
    rdy_i = 5'h0a;
    wreg(7'h37, 8'h00);
    step();
    `CHK(rdy_o, 5'h0a)
    for (int i = 0; i < 8; i++) begin
      wreg(7'h38, 8'h01 << i);
      step();
      `CHK(blk, 8'h01 << i)
    end
    nblk = 7'h55;
    wreg(7'h38, 8'h00);
    step();
    `CHK(blk, 8'haa)
    wreg(7'h35, 8'hd6);
    wreg(7'h36, 8'hbd);
    step();
    `CHK({dg, an}, 16'hd6bd)
    wreg(7'h35, 8'h00);
    wreg(7'h36, 8'h00);
  endtask
  // Mid-run reset clears registers and outputs again
  task automatic t_reset();
    wreg(7'h38, 8'hff);
    wreg(7'h35, 8'h5a);
    rst = 1'b1;
    step();
    step();
    rst = 1'b0;
    `CHK({dg, an, blk, sup, rdy_o, ft, start, dly}, {35'h0, 6'd40})
    rchk(7'h38, 8'h00, 1'b1);
    rchk(7'h35, 8'h00, 1'b1);
  endtask
  task automatic print_verdict();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the roughly 130 cycles the tests need
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    t_regs();
    t_demod();
    t_fine();
    t_force();
    t_reset();
    print_verdict();
  end
endmodule
